// File: pkg/scb_pkg.sv
// scb_pkg: constants, register map and state type of the system-control and block-move unit
// assumes a 32-bit APB slave port and a 16-bit on-chip memory port
package scb_pkg;
	// ----------------------------------------
	// apb register byte offsets
	// ----------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] REG_CMD = 8'h00, REG_CTRL = 8'h04, REG_FLAGS = 8'h08, REG_STACK = 8'h0c;
	localparam logic [7:0] REG_BASE = 8'h10, REG_DISP = 8'h14, REG_SRC = 8'h18, REG_DST = 8'h1c;
	localparam logic [7:0] REG_COUNT = 8'h20, REG_PC = 8'h24, REG_OPA = 8'h28, REG_OPB = 8'h2c;
	localparam logic [7:0] REG_STATUS = 8'h30;
	// ----------------------------------------
	// command field layout
	// ----------------------------------------
	localparam int unsigned OP_W = 5;
	localparam int unsigned CMD_IMM_LO = 8;
	localparam int unsigned FLAG_LANE = 8;
	// ----------------------------------------
	// operations
	// ----------------------------------------
	localparam logic [4:0] OP_SOFTWARE_TRAP = 5'h00, OP_RETURN_FROM_EXCEPTION = 5'h01, OP_POWER_DOWN = 5'h02;
	localparam logic [4:0] OP_LOAD_IMM = 5'h03, OP_LOAD_IND = 5'h04, OP_LOAD_D16 = 5'h05, OP_LOAD_D24 = 5'h06;
	localparam logic [4:0] OP_LOAD_INC = 5'h07, OP_STORE_IND = 5'h08, OP_STORE_D16 = 5'h09, OP_STORE_D24 = 5'h0a;
	localparam logic [4:0] OP_STORE_DEC = 5'h0b, OP_AND_FLAGS = 5'h0c, OP_OR_FLAGS = 5'h0d, OP_XOR_FLAGS = 5'h0e;
	localparam logic [4:0] OP_MOVE_BYTE = 5'h0f, OP_MOVE_WORD = 5'h10, OP_FLAG_EVAL = 5'h11;
	// ----------------------------------------
	// flag evaluation selects
	// ----------------------------------------
	localparam logic [3:0] ALU_ADDW = 4'h0, ALU_SUBW = 4'h1, ALU_ADDL = 4'h2, ALU_SUBL = 4'h3;
	localparam logic [3:0] ALU_ADDX = 4'h4, ALU_DAA = 4'h5, ALU_DIVD = 4'h6, ALU_DIVQ = 4'h7;
	// ----------------------------------------
	// flag bit positions
	// ----------------------------------------
	localparam int unsigned FLAG_I = 7, FLAG_H = 5, FLAG_N = 3, FLAG_Z = 2, FLAG_V = 1, FLAG_C = 0;
	// ----------------------------------------
	// execution state counts
	// ----------------------------------------
	localparam int unsigned CNT_W = 20;
	localparam logic [CNT_W-1:0] ST_TRAP_NORMAL = 20'h0000e, ST_TRAP_ADV = 20'h00010, ST_RET = 20'h0000a;
	localparam logic [CNT_W-1:0] ST_SLEEP = 20'h00002, ST_REG = 20'h00002, ST_IND = 20'h00006;
	localparam logic [CNT_W-1:0] ST_D16 = 20'h00008, ST_D24 = 20'h0000c, ST_INCDEC = 20'h00008;
	localparam logic [CNT_W-1:0] ST_MOVE_BASE = 20'h00008, ST_MOVE_PER = 20'h00004;
	localparam logic [31:0] WORD_STEP = 32'h00000002;
	localparam logic [2:0] STEP_TRAP_DONE = 3'h4, STEP_RET_DONE = 3'h3;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DOWN} scb_fsm_t;
endpackage

// File: rtl/scb_core.sv
// scb_core: system-control and block-move execution unit behind an apb register file
// assumes a memory port that holds mem_ready low to stretch an access
// Operation
// [RQ1] trap pushes pc, flags, loads vector, sets mask
// [RQ2] return pops flags then pc, restores flags
// [RQ3] power-down enters low power, two states
// [RQ4] load via base+d16 replaces all flags
// [RQ5] load via base+d24 reads word into flags
// [RQ6] post-increment load adds two to base
// [RQ7] pre-decrement store subtracts two, then writes
// [RQ8] store via base+d24 writes flags word
// [RQ9] byte move copies until 8-bit count zero
// [RQ10] word move uses 16-bit count, flags kept
// [RQ11] move takes eight plus four per byte
// [RQ12] state counts hold for zero-wait memory
// [RQ13] word arithmetic half-carry from bit 11
// [RQ14] long arithmetic half-carry from bit 27
// [RQ15] extended add keeps zero only if zero
// [RQ16] decimal adjust sets carry or keeps it
// [RQ17] stretched memory makes state count variable
// [RQ18] signed divide negative from divisor sign
// [RQ19] divide zero flag from zero divisor
// [RQ20] quotient form negative from quotient sign
// [RQ21] and/or/xor immediate combine into flags
`timescale 1ns/1ns
`default_nettype none
module scb_core #(
	parameter logic [31:0] VEC_BASE = 32'h00000010
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [scb_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// on-chip memory
	output logic mem_req,
	output logic mem_we,
	output logic mem_byte,
	output logic [31:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ready,
	// power control
	input wire logic wake,
	output logic sleep_mode,
	output logic busy
);
	import scb_pkg::*;

	typedef struct packed {
		scb_fsm_t fsm;
		logic [OP_W-1:0] op;
		logic [7:0] imm;
		logic adv;
		logic [2:0] step;
		logic [CNT_W-1:0] elapsed;
		logic [CNT_W-1:0] target;
		logic [CNT_W-1:0] last;
		logic [7:0] flags;
		logic [31:0] sp;
		logic [31:0] base;
		logic [31:0] disp;
		logic [31:0] pc;
		logic [31:0] opa;
		logic [31:0] opb;
		logic [15:0] src;
		logic [15:0] dst;
		logic [15:0] cnt;
		logic [7:0] mbuf;
		logic mem_req;
		logic mem_we;
		logic mem_byte;
		logic [31:0] mem_addr;
		logic [15:0] mem_wdata;
		logic [31:0] prdata;
		logic pslverr;
	} scb_state_t;

	scb_state_t s;
	scb_state_t next_s;

	// ----------------------------------------
	// execution length per operation
	// ----------------------------------------
	function automatic logic [CNT_W-1:0] state_target(input logic [OP_W-1:0] op, input logic adv,
		input logic [15:0] cnt);
		logic [CNT_W-1:0] n;
		n = (op == OP_MOVE_BYTE) ? CNT_W'(cnt[7:0]) : CNT_W'(cnt);
		case (op)
			OP_SOFTWARE_TRAP: state_target = adv ? ST_TRAP_ADV : ST_TRAP_NORMAL; // [RQ1]
			OP_RETURN_FROM_EXCEPTION: state_target = ST_RET;
			OP_POWER_DOWN: state_target = ST_SLEEP; // [RQ3]
			OP_LOAD_IND, OP_STORE_IND: state_target = ST_IND; // [RQ12]
			OP_LOAD_D16, OP_STORE_D16: state_target = ST_D16;
			OP_LOAD_D24, OP_STORE_D24: state_target = ST_D24;
			OP_LOAD_INC, OP_STORE_DEC: state_target = ST_INCDEC;
			OP_MOVE_BYTE, OP_MOVE_WORD: state_target = ST_MOVE_BASE + n * ST_MOVE_PER; // [RQ11]
			default: state_target = ST_REG;
		endcase
	endfunction

	// ----------------------------------------
	// arithmetic flag evaluation
	// ----------------------------------------
	function automatic logic [7:0] flag_eval(input logic [3:0] sel, input logic [31:0] a,
		input logic [31:0] b, input logic [7:0] f);
		logic [7:0] o;
		logic [16:0] w;
		logic [32:0] l;
		logic [12:0] hw;
		logic [28:0] hl;
		logic [8:0] x;
		logic [4:0] xh;
		logic [7:0] d;
		logic [15:0] am;
		logic [7:0] bm;
		logic sub;
		o = f;
		sub = sel[0];
		w = sub ? {1'b0, a[15:0]} - {1'b0, b[15:0]} : {1'b0, a[15:0]} + {1'b0, b[15:0]};
		l = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
		hw = sub ? {1'b0, a[11:0]} - {1'b0, b[11:0]} : {1'b0, a[11:0]} + {1'b0, b[11:0]};
		hl = sub ? {1'b0, a[27:0]} - {1'b0, b[27:0]} : {1'b0, a[27:0]} + {1'b0, b[27:0]};
		x = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, f[FLAG_C]};
		xh = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, f[FLAG_C]};
		d = a[7:0];
		am = a[15] ? 16'h0000 - a[15:0] : a[15:0];
		bm = b[7] ? 8'h00 - b[7:0] : b[7:0];
		case (sel)
			ALU_ADDW, ALU_SUBW: begin
				o[FLAG_H] = hw[12]; // [RQ13]
				o[FLAG_N] = w[15];
				o[FLAG_Z] = (w[15:0] == 16'h0000);
				o[FLAG_V] = (sub ? (a[15] != b[15]) : (a[15] == b[15])) && (w[15] != a[15]);
				o[FLAG_C] = w[16];
			end
			ALU_ADDL, ALU_SUBL: begin
				o[FLAG_H] = hl[28]; // [RQ14]
				o[FLAG_N] = l[31];
				o[FLAG_Z] = (l[31:0] == 32'h00000000);
				o[FLAG_V] = (sub ? (a[31] != b[31]) : (a[31] == b[31])) && (l[31] != a[31]);
				o[FLAG_C] = l[32];
			end
			ALU_ADDX: begin
				o[FLAG_H] = xh[4];
				o[FLAG_N] = x[7];
				o[FLAG_Z] = f[FLAG_Z] & (x[7:0] == 8'h00); // [RQ15]
				o[FLAG_V] = (a[7] == b[7]) && (x[7] != a[7]);
				o[FLAG_C] = x[8];
			end
			ALU_DAA: begin
				if (f[FLAG_C] || (d > 8'h99)) begin
					d = d + 8'h60;
					o[FLAG_C] = 1'b1; // [RQ16]
				end
				if (f[FLAG_H] || (a[3:0] > 4'h9)) begin
					d = d + 8'h06;
				end
				o[FLAG_N] = d[7];
				o[FLAG_Z] = (d == 8'h00);
			end
			ALU_DIVD: begin
				o[FLAG_N] = b[7]; // [RQ18]
				o[FLAG_Z] = (b[7:0] == 8'h00); // [RQ19]
			end
			ALU_DIVQ: begin
				o[FLAG_N] = (a[15] ^ b[7]) && (bm != 8'h00) && ({8'h00, bm} <= am); // [RQ20]
				o[FLAG_Z] = (b[7:0] == 8'h00); // [RQ19]
			end
			default: o = f;
		endcase
		flag_eval = o;
	endfunction

	logic apb_setup;
	logic apb_wr;
	logic seq_done;
	logic is_store;
	logic is_mem;
	logic [31:0] ea;
	logic [31:0] vec_addr;
	logic [2:0] step_inc;

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		next_s = s;
		apb_setup = psel & ~penable;
		apb_wr = psel & penable & pwrite;
		is_store = (s.op == OP_STORE_IND) || (s.op == OP_STORE_D16) || (s.op == OP_STORE_D24)
			|| (s.op == OP_STORE_DEC);
		is_mem = is_store || (s.op == OP_LOAD_IND) || (s.op == OP_LOAD_D16) || (s.op == OP_LOAD_D24)
			|| (s.op == OP_LOAD_INC);
		step_inc = ((s.step == 3'h0) && !s.adv) ? 3'h2 : s.step + 3'h1;
		vec_addr = VEC_BASE + (s.adv ? {28'h0, s.imm[1:0], 2'b00} : {29'h0, s.imm[1:0], 1'b0});
		case (s.op)
			OP_LOAD_D16, OP_STORE_D16: ea = s.base + {{16{s.disp[15]}}, s.disp[15:0]}; // [RQ4]
			OP_LOAD_D24, OP_STORE_D24: ea = s.base + {{8{s.disp[23]}}, s.disp[23:0]}; // [RQ5] [RQ8]
			OP_STORE_DEC: ea = s.base - WORD_STEP; // [RQ7]
			default: ea = s.base;
		endcase
		case (s.op)
			OP_SOFTWARE_TRAP: seq_done = (s.step == STEP_TRAP_DONE);
			OP_RETURN_FROM_EXCEPTION: seq_done = (s.step == STEP_RET_DONE);
			OP_MOVE_BYTE: seq_done = (s.step == 3'h0) && (s.cnt[7:0] == 8'h00); // [RQ9]
			OP_MOVE_WORD: seq_done = (s.step == 3'h0) && (s.cnt == 16'h0000); // [RQ10]
			default: seq_done = !is_mem || (s.step != 3'h0);
		endcase

		// apb read data captured in the setup phase
		if (apb_setup) begin
			next_s.pslverr = 1'b0;
			case (paddr)
				REG_CMD: next_s.prdata = {16'h0000, s.imm, 3'h0, s.op};
				REG_CTRL: next_s.prdata = {31'h0, s.adv};
				REG_FLAGS: next_s.prdata = {24'h000000, s.flags};
				REG_STACK: next_s.prdata = s.sp;
				REG_BASE: next_s.prdata = s.base;
				REG_DISP: next_s.prdata = s.disp;
				REG_SRC: next_s.prdata = {16'h0000, s.src};
				REG_DST: next_s.prdata = {16'h0000, s.dst};
				REG_COUNT: next_s.prdata = {16'h0000, s.cnt};
				REG_PC: next_s.prdata = s.pc;
				REG_OPA: next_s.prdata = s.opa;
				REG_OPB: next_s.prdata = s.opb;
				REG_STATUS: next_s.prdata = {4'h0, s.last, 6'h00, s.fsm == ST_DOWN, s.fsm != ST_IDLE};
				default: begin
					next_s.prdata = 32'h00000000;
					next_s.pslverr = 1'b1;
				end
			endcase
		end

		case (s.fsm)
			ST_IDLE: begin
				// writes only land while idle
				if (apb_wr) begin
					case (paddr)
						REG_CMD: begin
							if (pwdata[OP_W-1:0] <= OP_FLAG_EVAL) begin
								next_s.op = pwdata[OP_W-1:0];
								next_s.imm = pwdata[CMD_IMM_LO +: 8];
								next_s.step = 3'h0;
								next_s.elapsed = '0;
								next_s.target = state_target(pwdata[OP_W-1:0], s.adv, s.cnt);
								next_s.fsm = ST_RUN;
							end
						end
						REG_CTRL: next_s.adv = pwdata[0];
						REG_FLAGS: next_s.flags = pwdata[7:0];
						REG_STACK: next_s.sp = pwdata;
						REG_BASE: next_s.base = pwdata;
						REG_DISP: next_s.disp = pwdata;
						REG_SRC: next_s.src = pwdata[15:0];
						REG_DST: next_s.dst = pwdata[15:0];
						REG_COUNT: next_s.cnt = pwdata[15:0];
						REG_PC: next_s.pc = pwdata;
						REG_OPA: next_s.opa = pwdata;
						REG_OPB: next_s.opb = pwdata;
						default: next_s.op = s.op;
					endcase
				end
			end
			ST_RUN: begin
				next_s.elapsed = s.elapsed + 1'b1;
				if (s.mem_req) begin
					// stall while memory stretches the access
					if (mem_ready) begin // [RQ17]
						next_s.mem_req = 1'b0;
						next_s.step = s.step + 3'h1;
						case (s.op)
							OP_SOFTWARE_TRAP: begin
								next_s.step = step_inc;
								if (s.step == 3'h3) begin
									next_s.pc = {16'h0000, mem_rdata}; // [RQ1]
									next_s.flags[FLAG_I] = 1'b1;
								end
							end
							OP_RETURN_FROM_EXCEPTION: begin
								next_s.step = step_inc;
								next_s.sp = s.sp + WORD_STEP; // [RQ2]
								case (s.step)
									3'h0: next_s.flags = mem_rdata[FLAG_LANE +: 8];
									3'h1: next_s.pc[31:16] = mem_rdata;
									default: next_s.pc[15:0] = mem_rdata;
								endcase
							end
							OP_MOVE_BYTE, OP_MOVE_WORD: begin
								if (s.step == 3'h0) begin
									next_s.mbuf = mem_rdata[7:0];
								end else begin
									next_s.step = 3'h0;
									next_s.src = s.src + 16'h0001; // [RQ9]
									next_s.dst = s.dst + 16'h0001;
									if (s.op == OP_MOVE_BYTE) begin
										next_s.cnt[7:0] = s.cnt[7:0] - 8'h01;
									end else begin
										next_s.cnt = s.cnt - 16'h0001; // [RQ10]
									end
								end
							end
							default: begin
								if (!is_store) begin
									next_s.flags = mem_rdata[FLAG_LANE +: 8]; // [RQ4] [RQ5]
								end
								if (s.op == OP_LOAD_INC) begin
									next_s.base = s.base + WORD_STEP; // [RQ6]
								end
							end
						endcase
					end
				end else if (!seq_done) begin
					next_s.mem_req = 1'b1;
					next_s.mem_we = 1'b0;
					next_s.mem_byte = 1'b0;
					case (s.op)
						OP_SOFTWARE_TRAP: begin
							if (s.step == 3'h3) begin
								next_s.mem_addr = vec_addr;
							end else begin
								// pre-decrement push
								next_s.sp = s.sp - WORD_STEP; // [RQ1]
								next_s.mem_addr = s.sp - WORD_STEP;
								next_s.mem_we = 1'b1;
								case (s.step)
									3'h0: next_s.mem_wdata = s.pc[15:0];
									3'h1: next_s.mem_wdata = s.pc[31:16];
									default: next_s.mem_wdata = {s.flags, s.flags};
								endcase
							end
						end
						OP_RETURN_FROM_EXCEPTION: next_s.mem_addr = s.sp; // [RQ2]
						OP_MOVE_BYTE, OP_MOVE_WORD: begin
							next_s.mem_byte = 1'b1;
							next_s.mem_we = s.step[0];
							next_s.mem_addr = {16'h0000, s.step[0] ? s.dst : s.src};
							next_s.mem_wdata = {8'h00, s.mbuf};
						end
						default: begin
							next_s.mem_addr = ea;
							next_s.mem_we = is_store;
							next_s.mem_wdata = {s.flags, s.flags}; // [RQ8]
							if (s.op == OP_STORE_DEC) begin
								next_s.base = ea; // [RQ7]
							end
						end
					endcase
				end else if (s.elapsed >= s.target - 1'b1) begin
					next_s.last = s.elapsed + 1'b1;
					next_s.fsm = ST_IDLE;
					case (s.op)
						OP_POWER_DOWN: next_s.fsm = ST_DOWN; // [RQ3]
						OP_LOAD_IMM: next_s.flags = s.imm;
						OP_AND_FLAGS: next_s.flags = s.flags & s.imm; // [RQ21]
						OP_OR_FLAGS: next_s.flags = s.flags | s.imm; // [RQ21]
						OP_XOR_FLAGS: next_s.flags = s.flags ^ s.imm; // [RQ21]
						OP_FLAG_EVAL: next_s.flags = flag_eval(s.imm[3:0], s.opa, s.opb, s.flags);
						default: next_s.flags = s.flags;
					endcase
				end
			end
			ST_DOWN: begin
				if (wake) begin
					next_s.fsm = ST_IDLE;
				end
			end
			default: next_s.fsm = ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata = s.prdata;
	assign pready = 1'b1;
	assign pslverr = s.pslverr;
	assign mem_req = s.mem_req;
	assign mem_we = s.mem_we;
	assign mem_byte = s.mem_byte;
	assign mem_addr = s.mem_addr;
	assign mem_wdata = s.mem_wdata;
	assign sleep_mode = (s.fsm == ST_DOWN);
	assign busy = (s.fsm == ST_RUN);
endmodule
`default_nettype wire

// File: tb/scb_mem_model.sv
// scb_mem_model: byte array standing for on-chip memory and stack
// assumes big-endian words; stall adds two wait cycles to every access
`timescale 1ns/1ns
`default_nettype none
module scb_mem_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// memory port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic mem_byte,
	input wire logic [31:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata,
	output logic mem_ready,
	// test control
	input wire logic stall
);
	logic [7:0] mem [0:255];
	logic [1:0] waited;
	logic [15:0] last;
	logic [7:0] a;
	assign a = mem_addr[7:0];
	assign mem_ready = mem_req && (!stall || waited == 2'h2);
	// bus shows a changing pattern when no data is driven
	assign mem_rdata = !mem_ready ? ~last : mem_byte ? {8'h00, mem[a]} : {mem[a], mem[a + 8'h01]};
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			waited <= 2'h0;
			last <= 16'h0000;
		end else begin
			waited <= (mem_req && !mem_ready) ? waited + 2'h1 : 2'h0;
			last <= mem_rdata;
		end
	end
	always @(posedge pclk) begin
		if (mem_ready && mem_we && mem_byte) begin
			mem[a] <= mem_wdata[7:0];
		end else if (mem_ready && mem_we) begin
			mem[a] <= mem_wdata[15:8];
			mem[a + 8'h01] <= mem_wdata[7:0];
		end
	end
endmodule
`default_nettype wire

// File: tb/scb_monitor.sv
// scb_monitor: timing and bus checks on the unit's ports
// assumes software sets base, count and flags by register writes before use
`timescale 1ns/1ns
`default_nettype none
module scb_monitor #(
	parameter logic [31:0] VEC_BASE = 32'h00000010
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [scb_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic mem_byte,
	input wire logic [31:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ready,
	input wire logic wake,
	input wire logic sleep_mode,
	input wire logic busy
);
	import scb_pkg::*;
	logic wr, wr_cmd, adv, stalled, mv, nz;
	logic [15:0] cmd, n;
	logic [31:0] base;
	logic [7:0] flags;
	logic [19:0] cnt, len;
	assign wr = psel && penable && pwrite && !busy && !sleep_mode;
	assign wr_cmd = wr && paddr == REG_CMD && pwdata[4:0] <= OP_FLAG_EVAL;
	assign mv = cmd[4:0] == OP_MOVE_BYTE || cmd[4:0] == OP_MOVE_WORD;
	assign nz = cmd[4:0] == OP_MOVE_BYTE ? n[7:0] != 8'h00 : n != 16'h0000;
	always_ff @(posedge pclk) begin
		if (wr && paddr == REG_CMD) cmd <= pwdata[15:0];
		if (wr && paddr == REG_COUNT) n <= pwdata[15:0];
		if (wr && paddr == REG_BASE) base <= pwdata;
		if (wr && paddr == REG_FLAGS) flags <= pwdata[7:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 20'h0;
			stalled <= 1'b0;
			adv <= 1'b0;
		end else begin
			adv <= (wr && paddr == REG_CTRL) ? pwdata[0] : adv;
			cnt <= wr_cmd ? 20'h0 : cnt + {19'h0, busy};
			stalled <= !wr_cmd && (stalled || (mem_req && !mem_ready));
		end
	end
	// busy length of each command with zero-wait memory
	always_comb begin
		case (cmd[4:0])
			OP_SOFTWARE_TRAP: len = adv ? 20'h10 : 20'h0e;
			OP_RETURN_FROM_EXCEPTION: len = 20'h0a;
			OP_LOAD_IND, OP_STORE_IND: len = 20'h06;
			OP_LOAD_D16, OP_STORE_D16, OP_LOAD_INC, OP_STORE_DEC: len = 20'h08;
			OP_LOAD_D24, OP_STORE_D24: len = 20'h0c;
			OP_MOVE_BYTE: len = 20'h08 + {10'h0, n[7:0], 2'h0};
			OP_MOVE_WORD: len = 20'h08 + {2'h0, n, 2'h0};
			default: len = 20'h02;
		endcase
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_POWER_DOWN: assert property (
		wr_cmd && pwdata[4:0] == OP_POWER_DOWN |=> busy [*2] ##1 (sleep_mode && !busy))
		else $error("power-down timing wrong");
	AST_STATE_COUNT: assert property (
		$fell(busy) && !stalled && !mv |-> cnt == len) else $error("command state count wrong");
	AST_MOVE_LEN: assert property (
		$fell(busy) && !stalled && mv |-> cnt == len) else $error("move state count wrong");
	AST_MOVE_ZERO: assert property (
		busy && mv && !nz |-> !mem_req) else $error("zero-count move touched memory");
	AST_MOVE_BYTE: assert property (
		mem_req && mv |-> mem_byte) else $error("move access not byte wide");
	AST_STORE_DEC_ADDR: assert property (
		mem_req && cmd[4:0] == OP_STORE_DEC |-> mem_we && mem_addr == base - 32'h2) else $error("predec address");
	AST_STORE_DATA: assert property (
		mem_req && mem_we && cmd[4:0] >= OP_STORE_IND && cmd[4:0] <= OP_STORE_DEC |-> mem_wdata == {flags, flags})
		else $error("stored flags wrong");
	AST_TRAP_VEC: assert property (
		mem_req && !mem_we && cmd[4:0] == OP_SOFTWARE_TRAP |-> mem_addr == VEC_BASE + (adv ? 32'h4 : 32'h2) * cmd[9:8])
		else $error("vector address wrong");
	AST_MEM_HOLD: assert property (
		mem_req && !mem_ready |=> mem_req && $stable(mem_addr) && $stable(mem_we)) else $error("request dropped");
	cover property (wr_cmd && pwdata[4:0] == OP_SOFTWARE_TRAP);
	cover property (busy && mv && stalled);
	cover property (sleep_mode ##1 !sleep_mode);
endmodule
bind scb_core scb_monitor #(.VEC_BASE(VEC_BASE)) u_mon (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
	.mem_rdata(mem_rdata), .mem_ready(mem_ready), .wake(wake), .sleep_mode(sleep_mode), .busy(busy));
`default_nettype wire

// File: tb/tb_cpu_system_control_block_move.sv
// tb_cpu_system_control_block_move: apb command sequences with expected flags, registers and memory
// assumes the memory model of scb_mem_model and a 25 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_system_control_block_move;
	import scb_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_byte, mem_ready;
	logic wake, sleep_mode, busy, stall;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, mem_addr;
	logic [15:0] mem_wdata, mem_rdata;
	int err_total, checked, k;
	scb_core u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
		.mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ready(mem_ready), .wake(wake), .sleep_mode(sleep_mode), .busy(busy));
	scb_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready), .stall(stall));
	always #20 pclk = ~pclk;
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic test_done();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
		checked++;
		if ((got & m) !== (e & m)) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got & m, e & m);
		end
	endtask
	task automatic hang(input int i);
		if (i >= 400) begin
			err_total++;
			$display("Error at %0t: wait ran out", $time);
			test_done();
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rv);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 400);
		rv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		hang(i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] x;
		apb(a, 1'b1, v, x);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] x;
		apb(a, 1'b0, 32'h0, x);
		chk(x, e, m);
	endtask
	task automatic run(input logic [4:0] op, input logic [7:0] imm);
		int i;
		wr(REG_CMD, {16'h0, imm, 3'h0, op});
		i = 0;
		@(posedge pclk);
		while (busy !== 1'b0 && i < 400) begin
			@(posedge pclk);
			i++;
		end
		hang(i);
	endtask
	task automatic flags_op(input logic [4:0] op, input logic [7:0] imm, input logic [7:0] e);
		run(op, imm);
		rd(REG_FLAGS, {24'h0, e}, 32'hff);
	endtask
	task automatic eval(input logic [3:0] s, input logic [7:0] pre, input logic [31:0] a, input logic [31:0] b,
		input logic [7:0] m, input logic [7:0] e);
		wr(REG_FLAGS, {24'h0, pre});
		wr(REG_OPA, a);
		wr(REG_OPB, b);
		run(OP_FLAG_EVAL, {4'h0, s});
		rd(REG_FLAGS, {24'h0, e}, {24'h0, m});
	endtask
	function automatic logic [31:0] mw(input logic [7:0] a);
		return {16'h0, u_mem.mem[a], u_mem.mem[a + 8'h01]};
	endfunction
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, wake, stall} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(REG_FLAGS, 32'h0, 32'hffffffff);
		rd(8'h40, 32'h0, 32'hffffffff);
		chk({31'h0, pslverr}, 32'h1, 32'h1);
		flags_op(OP_LOAD_IMM, 8'h3c, 8'h3c);
		flags_op(OP_AND_FLAGS, 8'hf0, 8'h30);
		flags_op(OP_OR_FLAGS, 8'h81, 8'hb1);
		flags_op(OP_XOR_FLAGS, 8'hff, 8'h4e);
		$display("logic immediates done");
		u_mem.mem[8'h50] = 8'hc5;
		u_mem.mem[8'h40] = 8'h81;
		wr(REG_BASE, 32'h40);
		wr(REG_DISP, 32'h10);
		flags_op(OP_LOAD_D16, 8'h00, 8'hc5);
		u_mem.mem[8'h50] = 8'h2a;
		flags_op(OP_LOAD_D24, 8'h00, 8'h2a);
		flags_op(OP_LOAD_INC, 8'h00, 8'h81);
		rd(REG_BASE, 32'h42, 32'hffffffff);
		wr(REG_FLAGS, 32'h5a);
		wr(REG_BASE, 32'h60);
		run(OP_STORE_DEC, 8'h00);
		chk(mw(8'h5e), 32'h5a5a, 32'hffff);
		rd(REG_BASE, 32'h5e, 32'hffffffff);
		run(OP_STORE_D24, 8'h00);
		chk(mw(8'h6e), 32'h5a5a, 32'hffff);
		rd(REG_FLAGS, 32'h5a, 32'hff);
		$display("load and store done");
		wr(REG_FLAGS, 32'h05);
		wr(REG_STACK, 32'h80);
		wr(REG_PC, 32'h1234);
		u_mem.mem[8'h12] = 8'h00;
		u_mem.mem[8'h13] = 8'h90;
		run(OP_SOFTWARE_TRAP, 8'h01);
		chk(mw(8'h7e), 32'h1234, 32'hffff);
		chk(mw(8'h7c), 32'h0505, 32'hffff);
		rd(REG_PC, 32'h90, 32'hffffffff);
		rd(REG_FLAGS, 32'h85, 32'hff);
		rd(REG_STACK, 32'h7c, 32'hffffffff);
		u_mem.mem[8'h7c] = 8'h4a;
		run(OP_RETURN_FROM_EXCEPTION, 8'h00);
		rd(REG_FLAGS, 32'h4a, 32'hff);
		rd(REG_PC, 32'h1234, 32'hffff);
		rd(REG_STACK, 32'h80, 32'hffffffff);
		wr(REG_CTRL, 32'h1);
		wr(REG_PC, 32'h00021234);
		u_mem.mem[8'h14] = 8'h00;
		u_mem.mem[8'h15] = 8'ha0;
		run(OP_SOFTWARE_TRAP, 8'h01);
		chk(mw(8'h7c), 32'h0002, 32'hffff);
		rd(REG_PC, 32'ha0, 32'hffffffff);
		wr(REG_CTRL, 32'h0);
		$display("trap and return done");
		for (k = 0; k < 3; k++) begin
			u_mem.mem[8'ha0 + 8'(k)] = 8'h31 + 8'(k);
		end
		u_mem.mem[8'hc2] = 8'hee;
		wr(REG_SRC, 32'ha0);
		wr(REG_DST, 32'hb0);
		wr(REG_COUNT, 32'h0103);
		run(OP_MOVE_BYTE, 8'h00);
		for (k = 0; k < 3; k++) begin
			chk({24'h0, u_mem.mem[8'hb0 + 8'(k)]}, 32'h31 + k, 32'hff);
		end
		rd(REG_SRC, 32'ha3, 32'hffff);
		rd(REG_COUNT, 32'h0100, 32'hffff);
		stall <= 1'b1;
		wr(REG_SRC, 32'ha0);
		wr(REG_DST, 32'hc0);
		wr(REG_COUNT, 32'h2);
		run(OP_MOVE_WORD, 8'h00);
		chk(mw(8'hc0), 32'h3132, 32'hffff);
		chk({24'h0, u_mem.mem[8'hc2]}, 32'hee, 32'hff);
		rd(REG_COUNT, 32'h0, 32'hffff);
		rd(REG_FLAGS, 32'hca, 32'hff);
		stall <= 1'b0;
		wr(REG_COUNT, 32'h0);
		run(OP_MOVE_BYTE, 8'h00);
		rd(REG_SRC, 32'ha2, 32'hffff);
		$display("block moves done");
		run(OP_POWER_DOWN, 8'h00);
		rd(REG_STATUS, 32'h3, 32'h3);
		wr(REG_FLAGS, 32'hff);
		wake <= 1'b1;
		@(posedge pclk);
		wake <= 1'b0;
		rd(REG_STATUS, 32'h0, 32'h3);
		rd(REG_FLAGS, 32'hca, 32'hff);
		$display("power-down done");
		eval(ALU_ADDW, 8'h00, 32'h0800, 32'h0800, 8'h20, 8'h20);
		eval(ALU_SUBW, 8'h00, 32'h1000, 32'h0001, 8'h20, 8'h20);
		eval(ALU_ADDW, 8'h20, 32'h0100, 32'h0100, 8'h20, 8'h00);
		eval(ALU_ADDL, 8'h00, 32'h08000000, 32'h08000000, 8'h20, 8'h20);
		eval(ALU_SUBL, 8'h20, 32'h0, 32'h0, 8'h20, 8'h00);
		eval(ALU_ADDX, 8'h04, 32'h01, 32'h01, 8'h04, 8'h00);
		eval(ALU_ADDX, 8'h04, 32'hff, 32'h01, 8'h04, 8'h04);
		eval(ALU_DAA, 8'h00, 32'h9a, 32'h0, 8'h01, 8'h01);
		eval(ALU_DAA, 8'h01, 32'h12, 32'h0, 8'h01, 8'h01);
		eval(ALU_DIVD, 8'h00, 32'h10, 32'h80, 8'h08, 8'h08);
		eval(ALU_DIVD, 8'h0c, 32'h10, 32'h7f, 8'h0c, 8'h00);
		eval(ALU_DIVD, 8'h00, 32'h10, 32'h00, 8'h04, 8'h04);
		eval(ALU_DIVQ, 8'h00, 32'hfffe, 32'h01, 8'h08, 8'h08);
		$display("flag rules done");
		test_done();
	end
endmodule
`default_nettype wire
